// file: common/pio_pkg.sv
// Package for the programmable I/O port: register offsets, reset values,
// per-line fixed pull directions and line modes.
// Assumes a 16-bit register port addressed by even byte offsets.
package pio_pkg;

  localparam int unsigned NUM_LINES = 32;
  localparam int unsigned REG_W     = 16;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [15:0] OFS_MODE_LOW  = 16'hff70;
  localparam logic [15:0] OFS_DIR_LOW   = 16'hff72;
  localparam logic [15:0] OFS_DATA_LOW  = 16'hff74;
  localparam logic [15:0] OFS_MODE_HIGH = 16'hff76;
  localparam logic [15:0] OFS_DIR_HIGH  = 16'hff78;
  localparam logic [15:0] OFS_DATA_HIGH = 16'hff7a;
  localparam logic [15:0] OFS_STAT_LOW  = 16'hff7c;
  localparam logic [15:0] OFS_STAT_HIGH = 16'hff7e;
  localparam logic [15:0] OFS_OD_LOW    = 16'hff6c;
  localparam logic [15:0] OFS_OD_HIGH   = 16'hff6e;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] RST_MODE_LOW  = 16'h0000;
  localparam logic [15:0] RST_DIR_LOW   = 16'hfc0f;
  localparam logic [15:0] RST_MODE_HIGH = 16'h0000;
  localparam logic [15:0] RST_DIR_HIGH  = 16'hffff;
  localparam logic [15:0] RST_DATA      = 16'h0000;
  localparam logic [15:0] RST_OD        = 16'h0000;

  // ---------------------------------------------------------------------
  // Fixed per-line properties
  // ---------------------------------------------------------------------
  // A one marks a line whose weak pull acts downward.
  localparam logic [31:0] PULL_DOWN_MASK = 32'h0000_0442;
  // Lines behind an external inverter: input only, read inverted.
  localparam logic [31:0] INV_INPUT_MASK = 32'hc000_0000;

  typedef enum logic [1:0] {
    PIO_NORMAL,
    PIO_IN_PULL,
    PIO_OUTPUT,
    PIO_IN_NOPULL
  } pio_mode_t;

  function automatic pio_mode_t pio_line_mode(input logic m,
                                              input logic d);
    return pio_mode_t'({m, d});
  endfunction

endpackage

// file: common/pio_cfg_if.sv
// Interface carrying line configuration from the register file to the
// pad steering logic, and the steered pad controls back.
// Assumes both ends share the system clock domain.
`timescale 1ns/1ps
interface pio_cfg_if;
  logic [31:0] mode;
  logic [31:0] dir;
  logic [31:0] od;
  logic [31:0] data;
  logic [31:0] periph_out;
  logic [31:0] periph_oe;
  logic [31:0] pad_out;
  logic [31:0] pad_oe;
  logic [31:0] pull_en;

  modport regs  (output mode, dir, od, data, periph_out, periph_oe,
                 input pad_out, pad_oe, pull_en);
  modport steer (input mode, dir, od, data, periph_out, periph_oe,
                 output pad_out, pad_oe, pull_en);
endinterface

// file: design/pio_pad_steer.sv
// Per-line pad steering: picks peripheral, input or output behaviour
// from the mode and direction bits of each line.
// Assumes configuration arrives from registers on the same clock.
`timescale 1ns/1ps
module pio_pad_steer
(
  pio_cfg_if.steer cfg
);

  import pio_pkg::*;

  logic [31:0] out_v;
  logic [31:0] oe_v;
  logic [31:0] pull_v;

  always_comb begin
    out_v  = '0;
    oe_v   = '0;
    pull_v = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      // RULE5: mode pair decode
      unique case (pio_line_mode(cfg.mode[i], cfg.dir[i]))
        PIO_NORMAL: begin
          out_v[i] = cfg.periph_out[i];
          oe_v[i]  = cfg.periph_oe[i];
        end
        PIO_IN_PULL: begin
          // RULE3: pull only enabled
          pull_v[i] = 1'b1;
        end
        PIO_OUTPUT: begin
          // RULE9: drive when output
          // RULE2: open-drain option
          out_v[i] = cfg.od[i] ? 1'b0 : cfg.data[i];
          oe_v[i]  = cfg.od[i] ? ~cfg.data[i] : 1'b1;
        end
        PIO_IN_NOPULL: begin
          pull_v[i] = 1'b0;
        end
      endcase
      // RULE10: inverter lines never driven
      if (INV_INPUT_MASK[i]) begin
        oe_v[i] = 1'b0;
      end
    end
  end

  assign cfg.pad_out = out_v;
  assign cfg.pad_oe  = oe_v;
  assign cfg.pull_en = pull_v;

endmodule

// file: design/pio_port.sv
// Top of the programmable I/O port: 16-bit register port, line
// configuration registers, input synchronisers and pad steering.
// Assumes pads are resolved outside from out, oe and pull controls.
`timescale 1ns/1ps

// Functional notes
// RULE1: Thirty-two lines, shared or general purpose.
// RULE2: Input, output, pulled, or open-drain per line.
// RULE3: Pull direction fixed; software only enables.
// RULE4: Mode and direction held in 16-bit registers.
// RULE5: Mode pair selects normal, input, output.
// RULE6: Reset gives pull-up, some pull-down, normal.
// RULE7: Board must not hold strap lines low.
// RULE8: Status read returns sixteen lines per group.
// RULE9: Data drives pin only in output mode.
// RULE10: Inverter-shared interrupt lines are inputs only.
// RULE11: Inverter-shared lines read as complement.
// RULE12: Software leaves on-board component lines alone.
// RULE13: Bit n controls line n; high pair.
module pio_port
(
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic [31:0] pad_in_in,
  output logic      [31:0] pad_out_out,
  output logic      [31:0] pad_oe_out,
  output logic      [31:0] pad_pull_en_out,
  output logic      [31:0] pad_pull_up_out,
  input  wire logic [31:0] periph_out_in,
  input  wire logic [31:0] periph_oe_in,
  output logic      [31:0] periph_in_out
);

  import pio_pkg::*;

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  logic [15:0] mode_lo_r;
  logic [15:0] mode_hi_r;
  logic [15:0] dir_lo_r;
  logic [15:0] dir_hi_r;
  logic [15:0] data_lo_r;
  logic [15:0] data_hi_r;
  logic [15:0] od_lo_r;
  logic [15:0] od_hi_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [31:0] sync1_r;
  logic [31:0] sync2_r;
  logic [31:0] line_stat;

  pio_cfg_if cfg ();

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  // One comparator shape for every offset keeps the map in one place.
  function automatic logic reg_hit(input logic [15:0] addr,
                                   input logic [15:0] ofs);
    return addr == ofs;
  endfunction

  wire hit_mode_lo = reg_hit(reg_addr_in, OFS_MODE_LOW);
  wire hit_mode_hi = reg_hit(reg_addr_in, OFS_MODE_HIGH);
  wire hit_dir_lo  = reg_hit(reg_addr_in, OFS_DIR_LOW);
  wire hit_dir_hi  = reg_hit(reg_addr_in, OFS_DIR_HIGH);
  wire hit_data_lo = reg_hit(reg_addr_in, OFS_DATA_LOW);
  wire hit_data_hi = reg_hit(reg_addr_in, OFS_DATA_HIGH);
  wire hit_stat_lo = reg_hit(reg_addr_in, OFS_STAT_LOW);
  wire hit_stat_hi = reg_hit(reg_addr_in, OFS_STAT_HIGH);
  wire hit_od_lo   = reg_hit(reg_addr_in, OFS_OD_LOW);
  wire hit_od_hi   = reg_hit(reg_addr_in, OFS_OD_HIGH);

  // Status offsets get no write enable, so writes there fall away.
  wire we_mode_lo  = reg_wr_in & hit_mode_lo;
  wire we_mode_hi  = reg_wr_in & hit_mode_hi;
  wire we_dir_lo   = reg_wr_in & hit_dir_lo;
  wire we_dir_hi   = reg_wr_in & hit_dir_hi;
  wire we_data_lo  = reg_wr_in & hit_data_lo;
  wire we_data_hi  = reg_wr_in & hit_data_hi;
  wire we_od_lo    = reg_wr_in & hit_od_lo;
  wire we_od_hi    = reg_wr_in & hit_od_hi;

  // -----------------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------------
  // RULE4: two 16-bit config registers
  // RULE6: reset line configuration
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      mode_lo_r <= RST_MODE_LOW;
      mode_hi_r <= RST_MODE_HIGH;
    end else begin
      if (we_mode_lo) begin
        mode_lo_r <= reg_wdata_in;
      end
      if (we_mode_hi) begin
        mode_hi_r <= reg_wdata_in;
      end
    end
  end

  // RULE13: high pair for upper lines
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      dir_lo_r <= RST_DIR_LOW;
      dir_hi_r <= RST_DIR_HIGH;
    end else begin
      if (we_dir_lo) begin
        dir_lo_r <= reg_wdata_in;
      end
      if (we_dir_hi) begin
        dir_hi_r <= reg_wdata_in;
      end
    end
  end

  // RULE2: open-drain select bits
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      od_lo_r <= RST_OD;
      od_hi_r <= RST_OD;
    end else begin
      if (we_od_lo) begin
        od_lo_r <= reg_wdata_in;
      end
      if (we_od_hi) begin
        od_hi_r <= reg_wdata_in;
      end
    end
  end

  // Output data is held even while a line is not in output mode, so a
  // level can be staged before the mode is switched without a glitch.
  // RULE9: stored output levels
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      data_lo_r <= RST_DATA;
      data_hi_r <= RST_DATA;
    end else begin
      if (we_data_lo) begin
        data_lo_r <= reg_wdata_in;
      end
      if (we_data_hi) begin
        data_hi_r <= reg_wdata_in;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------------
  // Pins move with no regard to the clock, so only the second stage is
  // read by logic; the first may still be settling.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sync1_r <= '0;
    end else begin
      sync1_r <= pad_in_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sync2_r <= '0;
    end else begin
      sync2_r <= sync1_r;
    end
  end

  // RULE11: complement inverter lines
  assign line_stat     = sync2_r ^ INV_INPUT_MASK;
  assign periph_in_out = line_stat;

  // -----------------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------------
  // RULE8: status in 16-line groups
  assign rdata_nxt = hit_mode_lo ? mode_lo_r :
                     hit_mode_hi ? mode_hi_r :
                     hit_dir_lo  ? dir_lo_r  :
                     hit_dir_hi  ? dir_hi_r  :
                     hit_data_lo ? data_lo_r :
                     hit_data_hi ? data_hi_r :
                     hit_od_lo   ? od_lo_r   :
                     hit_od_hi   ? od_hi_r   :
                     hit_stat_lo ? line_stat[15:0]  :
                     hit_stat_hi ? line_stat[31:16] :
                     16'h0000;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd_in) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // -----------------------------------------------------------------------
  // Pad steering
  // -----------------------------------------------------------------------
  // RULE1: all 32 lines steered
  assign cfg.mode       = {mode_hi_r, mode_lo_r};
  assign cfg.dir        = {dir_hi_r, dir_lo_r};
  assign cfg.od         = {od_hi_r, od_lo_r};
  assign cfg.data       = {data_hi_r, data_lo_r};
  assign cfg.periph_out = periph_out_in;
  assign cfg.periph_oe  = periph_oe_in;

  pio_pad_steer u_steer (
    .cfg (cfg.steer)
  );

  // Strap lines keep their pull-up from reset, so nothing here pulls
  // them low; the board must not either while reset is applied.
  // RULE7: straps rely on pull-up
  // RULE3: fixed pull direction
  assign pad_out_out     = cfg.pad_out;
  assign pad_oe_out      = cfg.pad_oe;
  assign pad_pull_en_out = cfg.pull_en;
  assign pad_pull_up_out = ~PULL_DOWN_MASK;

endmodule

// file: sim/pio_port_checker.sv
// Checker for the programmable I/O port, bound to the top-level ports.
// Assumes one clock domain and the register offsets of pio_pkg.
`timescale 1ns/1ps
module pio_port_checker
  import pio_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        srst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [31:0] pad_in_in,
  input wire logic [31:0] pad_out_out,
  input wire logic [31:0] pad_oe_out,
  input wire logic [31:0] pad_pull_en_out,
  input wire logic [31:0] pad_pull_up_out,
  input wire logic [31:0] periph_out_in,
  input wire logic [31:0] periph_oe_in,
  input wire logic [31:0] periph_in_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  fixed_pull_dir_a: assert property (pad_pull_up_out == 32'hffff_fbbd)
    else $error("pull direction changed");
  irq_lines_input_a: assert property (pad_oe_out[31:30] == 2'b00)
    else $error("inverted line driven");
  sync_invert_a: assert property (
    !$past(srst_in) && !$past(srst_in, 2)
    |-> periph_in_out == ($past(pad_in_in, 2) ^ 32'hc000_0000))
    else $error("synchronised level wrong");
  reset_pull_a: assert property ($past(srst_in)
    |-> pad_pull_en_out == 32'hffff_fc0f) else $error("reset pulls wrong");
  normal_follow_a: assert property ($past(srst_in)
    |-> pad_oe_out[9:4] == periph_oe_in[9:4]
    && pad_out_out[9:4] == periph_out_in[9:4]) else $error("normal lines");
  status_low_a: assert property (
    reg_rd_in && reg_addr_in == OFS_STAT_LOW
    |=> reg_rdata_out == $past(periph_in_out[15:0]))
    else $error("low status");
  status_high_a: assert property (
    reg_rd_in && reg_addr_in == OFS_STAT_HIGH
    |=> reg_rdata_out == $past(periph_in_out[31:16]))
    else $error("hi status");
  read_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  pull_drive_excl_a: assert property (
    (pad_pull_en_out & pad_oe_out) == 32'h0)
    else $error("pull on driven line");
endmodule

bind pio_port pio_port_checker pio_port_checker_i (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .pad_in_in(pad_in_in), .pad_out_out(pad_out_out), .pad_oe_out(pad_oe_out),
  .pad_pull_en_out(pad_pull_en_out), .pad_pull_up_out(pad_pull_up_out),
  .periph_out_in(periph_out_in), .periph_oe_in(periph_oe_in),
  .periph_in_out(periph_in_out));

// file: sim/pio_board_model.sv
// Board model: resolves each pin from port drive, board drive and pulls.
// Assumes the bench sets board levels; a floating pin toggles each cycle.
`timescale 1ns/1ps
module pio_board_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [31:0] out_in,
  input  wire logic [31:0] oe_in,
  input  wire logic [31:0] pull_en_in,
  input  wire logic [31:0] pull_up_in,
  input  wire logic [31:0] ext_lvl_in,
  input  wire logic [31:0] ext_drv_in,
  output logic      [31:0] pin_out
);
  logic        float_r = 1'b0;
  logic [31:0] drv;
  always_ff @(posedge clk_in) float_r <= ~float_r;
  // Strap lines are let go during reset so they are never held low then.
  // strap lines released
  assign drv = ext_drv_in & ~(rst_in ? 32'h2400_0000 : 32'h0000_0000);
  assign pin_out = (oe_in & out_in) | (~oe_in & drv & ext_lvl_in)
    | (~oe_in & ~drv & pull_en_in & pull_up_in)
    | (~oe_in & ~drv & ~pull_en_in & {32{float_r}});
endmodule

// file: sim/programmable_io_port_test.sv
// Testbench for the programmable I/O port, driving the register port.
// Assumes the board model closes the pin loop; inputs move at negedge.
`timescale 1ns/1ps
module programmable_io_port_test;
  import pio_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic        wr = 1'b0, rd = 1'b0;
  logic [31:0] pin, pout, poe, pen, pup, psync;
  logic [31:0] p_out = 32'h0000_0150, p_oe = 32'h0000_13f0;
  logic [31:0] lvl = 32'h0000_0000, drv = 32'h0000_0000;
  int          failures = 0, samples_checked = 0;

  always #5 clk_sys_in = ~clk_sys_in;
  pio_port pio_port_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .pad_in_in(pin),
    .pad_out_out(pout), .pad_oe_out(poe), .pad_pull_en_out(pen),
    .pad_pull_up_out(pup), .periph_out_in(p_out), .periph_oe_in(p_oe),
    .periph_in_out(psync));
  pio_board_model pio_board_model_i (.clk_in(clk_sys_in), .rst_in(srst_in),
    .out_in(pout), .oe_in(poe), .pull_en_in(pen), .pull_up_in(pup),
    .ext_lvl_in(lvl), .ext_drv_in(drv), .pin_out(pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk_sys_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_in);
    rd = 1'b0;
    chk({16'h0000, rdata}, {16'h0000, exp});
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clk_sys_in);
    srst_in = 1'b0;
    @(negedge clk_sys_in);
    chk(pen, 32'hffff_fc0f);
    chk(pup, 32'hffff_fbbd);
    chk(poe, 32'h0000_03f0);
    chk(pout & 32'h0000_03f0, 32'h0000_0150);
    rd_reg(16'hff72, 16'hfc0f);
    rd_reg(16'hff70, 16'h0000);
    rd_reg(16'hff78, 16'hffff);
    rd_reg(16'h0000, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr_reg(16'hff70, m[1] ? 16'h1000 : 16'h0000);
      wr_reg(16'hff72, m[0] ? 16'h3000 : 16'h2000);
      chk({30'h0, poe[12], pen[12]}, {30'h0, ~m[0], m == 1});
    end
    wr_reg(16'hff70, 16'h1000);
    wr_reg(16'hff72, 16'h2000);
    wr_reg(16'hff74, 16'h3000);
    chk({29'h0, pout[12], poe[12], poe[13]}, 32'h0000_0006);
    wr_reg(16'hff74, 16'h0000);
    chk({30'h0, pout[12], poe[12]}, 32'h0000_0001);
    wr_reg(16'hff6c, 16'h1000);
    chk({30'h0, pout[12], poe[12]}, 32'h0000_0001);
    wr_reg(16'hff74, 16'h1000);
    chk({30'h0, pout[12], poe[12]}, 32'h0000_0000);
    wr_reg(16'hff76, 16'hc000);
    wr_reg(16'hff78, 16'h0000);
    wr_reg(16'hff7a, 16'hc000);
    chk({30'h0, poe[31:30]}, 32'h0000_0000);
    lvl = 32'h3c5a_a5c3;
    drv = 32'hffff_ffff;
    wr_reg(16'hff70, 16'hffff);
    wr_reg(16'hff72, 16'hffff);
    wr_reg(16'hff76, 16'hffff);
    wr_reg(16'hff78, 16'hffff);
    rd_reg(16'hff7c, 16'ha5c3);
    rd_reg(16'hff7e, 16'hfc5a);
    chk(psync, 32'hfc5a_a5c3);
    wr_reg(16'hff7c, 16'h1234);
    rd_reg(16'hff7c, 16'ha5c3);
    srst_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    srst_in = 1'b0;
    @(negedge clk_sys_in);
    chk(pen, 32'hffff_fc0f);
    chk(poe, 32'h0000_03f0);
    rd_reg(16'hff70, 16'h0000);
    rd_reg(16'hff72, 16'hfc0f);
    close_out;
  end

  initial begin
    repeat (3000) @(posedge clk_sys_in);
    failures++;
    close_out;
  end
endmodule
